// >>> design/tmr_defs.vh
// tmr_defs.vh: constants for the timer channel (offsets, fields, codes, resets)
// assumes: included by bare name from design files; definitions only
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// counter width
`define TMR_CNT_W 24

// register byte offsets on the avalon slave
`define TMR_ADDR_W 4
`define TMR_OFS_CSR 4'h0
`define TMR_OFS_LOAD 4'h4
`define TMR_OFS_CMP 4'h8
`define TMR_OFS_COUNT 4'hC

// control_status_reg field positions
`define TMR_B_TE 0
`define TMR_B_OIE 1
`define TMR_B_CIE 2
`define TMR_B_MODE_LO 4
`define TMR_B_POL 8
`define TMR_B_TRM 9
`define TMR_B_DIN 12
`define TMR_B_PCE 15
`define TMR_B_OF 20
`define TMR_B_CF 21

// mode_select_field codes
`define TMR_MODE_W 4
`define TMR_M_TIMER 4'h0
`define TMR_M_PULSE 4'h1
`define TMR_M_TOGGLE 4'h2
`define TMR_M_EVENT 4'h3
`define TMR_M_WIDTH 4'h4
`define TMR_M_PERIOD 4'h5
`define TMR_M_CAPTURE 4'h6

// reset values
`define TMR_RST_MODE 4'h0
`define TMR_RST_CNT 24'h000000
`define TMR_RST_WORD 32'h00000000

`endif

// >>> design/tmr_channel.v
// tmr_channel.v: one timer channel with timer, pulse, toggle, event counter,
// pulse-width, period and capture modes, behind an avalon-mm slave.
// assumes: single clock sys_clk, timer_pin_in and prescaled_tick synchronous
// to sys_clk, prescaled_tick a one-cycle enable pulse from an outside prescaler.
//
// Chosen here: the Avalon-MM register port and the address map.

`timescale 1ns/10ps
`include "tmr_defs.vh"

module tmr_channel #(
	parameter CW = `TMR_CNT_W
) (
	input wire sys_clk,
	input wire nrst,
	input wire [`TMR_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire prescaled_tick,
	input wire timer_pin_in,
	output reg timer_pin_out,
	output reg timer_pin_oe,
	input wire compare_irq_ack,
	input wire overflow_irq_ack,
	output wire compare_irq,
	output wire overflow_irq
);

	// merge byte lanes of a write into the old word
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		integer i;
		begin
			be_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					be_merge[8*i +: 8] = wd[8*i +: 8];
				end
			end
		end
	endfunction

	// control_status_reg fields, load and compare values
	reg timer_enable_q;
	reg overflow_irq_enable_q;
	reg compare_irq_enable_q;
	reg [`TMR_MODE_W-1:0] mode_select_field_q;
	reg pin_polarity_flip_q;
	reg reload_on_match_q;
	reg prescaled_source_select_q;
	reg overflow_flag_q;
	reg compare_flag_q;
	reg [CW-1:0] load_value_reg_q;
	reg [CW-1:0] compare_value_reg_q;

	// counter datapath
	reg [CW-1:0] cnt_q;
	reg [CW-1:0] cnt_d;
	reg [CW-1:0] cap_q;
	reg [CW-1:0] cap_d;
	reg loaded_q;
	reg loaded_d;
	reg pend_q;
	reg pend_d;
	reg seen_q;
	reg seen_d;
	reg stop_q;
	reg stop_d;
	reg pin_d;
	reg cf_set;
	reg of_set;
	wire [CW:0] inc;

	// bus handshake, clk/2 divider and pin synchroniser
	reg ack_q;
	reg div_q;
	reg pin_s1_q;
	reg pin_s2_q;
	reg pin_s3_q;

	wire [`TMR_MODE_W-1:0] mode;
	wire pol;
	wire reload_on_match;
	wire bus_req;
	wire wr_go;
	wire wr_csr;
	wire [31:0] csr_view;
	wire [31:0] csr_w;
	wire [31:0] load_w;
	wire [31:0] cmp_w;
	wire te_set;
	wire lvl;
	wire lvl_prev;
	wire act_edge;
	wire inact_edge;
	wire tick;
	wire meas_mode;
	wire out_mode;
	wire out_mode_w;
	wire [CW-1:0] count_view;
	wire cf_clr;
	wire of_clr;

	assign mode = mode_select_field_q;
	assign pol = pin_polarity_flip_q;
	assign reload_on_match = reload_on_match_q;

	// one wait state: the request is answered at the second edge
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_q;
	assign wr_go = avs_write & ack_q;
	assign wr_csr = wr_go & (avs_address == `TMR_OFS_CSR);

	// pin level seen through the polarity bit; s1 feeds only s2
	assign lvl = pin_s2_q ^ pol;
	assign lvl_prev = pin_s3_q ^ pol;
	assign act_edge = lvl & ~lvl_prev;
	assign inact_edge = ~lvl & lvl_prev;

	// timer clock: prescaler wins, else pin edges in mode 3, else clk/2
	assign tick = timer_enable_q & (prescaled_source_select_q ? prescaled_tick :
		((mode == `TMR_M_EVENT) ? act_edge : div_q));

	assign meas_mode = (mode == `TMR_M_WIDTH) | (mode == `TMR_M_PERIOD) | (mode == `TMR_M_CAPTURE);
	assign out_mode = (mode == `TMR_M_PULSE) | (mode == `TMR_M_TOGGLE);
	// mode being written, so the enabling write already drives the pin
	assign out_mode_w = (csr_w[`TMR_B_MODE_LO +: `TMR_MODE_W] == `TMR_M_PULSE) |
		(csr_w[`TMR_B_MODE_LO +: `TMR_MODE_W] == `TMR_M_TOGGLE);
	assign inc = {1'b0, cnt_q} + {{CW{1'b0}}, 1'b1};

	// measurement modes show the captured result, others the live count
	assign count_view = meas_mode ? cap_q : cnt_q;

	// register images and merged write words
	assign csr_view = {10'h000, compare_flag_q, overflow_flag_q, 4'h0, prescaled_source_select_q,
		2'b00, lvl, 2'b00, reload_on_match_q, pin_polarity_flip_q, mode_select_field_q,
		1'b0, compare_irq_enable_q, overflow_irq_enable_q, timer_enable_q};
	assign csr_w = be_merge(csr_view, avs_writedata, avs_byteenable);
	assign load_w = be_merge({{(32-CW){1'b0}}, load_value_reg_q}, avs_writedata, avs_byteenable);
	assign cmp_w = be_merge({{(32-CW){1'b0}}, compare_value_reg_q}, avs_writedata, avs_byteenable);
	assign te_set = wr_csr & csr_w[`TMR_B_TE] & ~timer_enable_q;

	// flags clear on a written one or an acknowledge; a new set wins
	assign cf_clr = (wr_csr & avs_writedata[`TMR_B_CF] & avs_byteenable[2]) | compare_irq_ack;
	assign of_clr = (wr_csr & avs_writedata[`TMR_B_OF] & avs_byteenable[2]) | overflow_irq_ack;

	// interrupt lines are gated flags
	assign compare_irq = compare_flag_q & compare_irq_enable_q;
	assign overflow_irq = overflow_flag_q & overflow_irq_enable_q;

	// next-state logic of the counter for every mode
	always @* begin
		cnt_d = cnt_q;
		cap_d = cap_q;
		loaded_d = loaded_q;
		pend_d = pend_q;
		seen_d = seen_q;
		stop_d = stop_q;
		pin_d = timer_pin_out;
		cf_set = 1'b0;
		of_set = 1'b0;
		if (te_set) begin
			// enable clears the count and presets the pin
			cnt_d = {CW{1'b0}};
			loaded_d = 1'b0;
			pend_d = 1'b0;
			seen_d = 1'b0;
			stop_d = 1'b0;
			pin_d = csr_w[`TMR_B_POL];
		end else if (timer_enable_q) begin
			case (mode)
				`TMR_M_TIMER, `TMR_M_PULSE, `TMR_M_TOGGLE, `TMR_M_EVENT: begin
					if (tick) begin
						// a pulse lasts exactly one timer clock
						if (mode == `TMR_M_PULSE) begin
							pin_d = pol;
						end
						if (!loaded_q) begin
							cnt_d = load_value_reg_q;
							loaded_d = 1'b1;
						end else if (pend_q & reload_on_match) begin
							cnt_d = load_value_reg_q;
						end else begin
							{of_set, cnt_d} = inc;
						end
						pend_d = 1'b0;
						if (cnt_d == compare_value_reg_q) begin
							cf_set = 1'b1;
							pend_d = 1'b1;
							if (mode == `TMR_M_PULSE) begin
								pin_d = ~pol;
							end
							if (mode == `TMR_M_TOGGLE) begin
								pin_d = ~timer_pin_out;
							end
						end
					end
				end
				`TMR_M_WIDTH: begin
					// counting only while the pin sits at its active level
					if (tick & seen_q & lvl) begin
						if (pend_q) begin
							cnt_d = load_value_reg_q;
							pend_d = 1'b0;
						end else begin
							{of_set, cnt_d} = inc;
						end
					end
					if (act_edge) begin
						if (!seen_q | reload_on_match) begin
							pend_d = 1'b1;
						end
						seen_d = 1'b1;
					end
					if (inact_edge & seen_q) begin
						cf_set = 1'b1;
						cap_d = cnt_q;
					end
				end
				`TMR_M_PERIOD: begin
					if (tick & seen_q) begin
						if (pend_q) begin
							cnt_d = load_value_reg_q;
							pend_d = 1'b0;
						end else begin
							{of_set, cnt_d} = inc;
						end
					end
					if (act_edge) begin
						if (!seen_q) begin
							seen_d = 1'b1;
							pend_d = 1'b1;
						end else begin
							cf_set = 1'b1;
							cap_d = cnt_q;
							if (reload_on_match) begin
								pend_d = 1'b1;
							end
						end
					end
				end
				`TMR_M_CAPTURE: begin
					if (tick & ~stop_q) begin
						if (!loaded_q) begin
							cnt_d = load_value_reg_q;
							loaded_d = 1'b1;
						end else begin
							{of_set, cnt_d} = inc;
						end
					end
					// only the first selected edge is taken
					if (act_edge & ~stop_q) begin
						cf_set = 1'b1;
						cap_d = cnt_q;
						stop_d = 1'b1;
					end
				end
				default: begin
					// other codes are not served by this channel: the counter holds
					cnt_d = cnt_q;
				end
			endcase
		end
	end

	// avalon handshake and read data; read data stand at the answering edge
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			avs_readdata <= `TMR_RST_WORD;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (avs_read & ~ack_q) begin
				case (avs_address)
					`TMR_OFS_CSR: avs_readdata <= csr_view;
					`TMR_OFS_LOAD: avs_readdata <= {{(32-CW){1'b0}}, load_value_reg_q};
					`TMR_OFS_CMP: avs_readdata <= {{(32-CW){1'b0}}, compare_value_reg_q};
					`TMR_OFS_COUNT: avs_readdata <= {{(32-CW){1'b0}}, count_view};
					default: avs_readdata <= `TMR_RST_WORD;
				endcase
			end
		end
	end

	// software-written configuration
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			timer_enable_q <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
			compare_irq_enable_q <= 1'b0;
			mode_select_field_q <= `TMR_RST_MODE;
			pin_polarity_flip_q <= 1'b0;
			reload_on_match_q <= 1'b0;
			prescaled_source_select_q <= 1'b0;
			load_value_reg_q <= `TMR_RST_CNT;
			compare_value_reg_q <= `TMR_RST_CNT;
		end else begin
			if (wr_csr) begin
				timer_enable_q <= csr_w[`TMR_B_TE];
				overflow_irq_enable_q <= csr_w[`TMR_B_OIE];
				compare_irq_enable_q <= csr_w[`TMR_B_CIE];
				mode_select_field_q <= csr_w[`TMR_B_MODE_LO +: `TMR_MODE_W];
				pin_polarity_flip_q <= csr_w[`TMR_B_POL];
				reload_on_match_q <= csr_w[`TMR_B_TRM];
				prescaled_source_select_q <= csr_w[`TMR_B_PCE];
			end
			if (wr_go & (avs_address == `TMR_OFS_LOAD)) begin
				load_value_reg_q <= load_w[CW-1:0];
			end
			if (wr_go & (avs_address == `TMR_OFS_CMP)) begin
				compare_value_reg_q <= cmp_w[CW-1:0];
			end
		end
	end

	// status flags: set has priority over any clear in the same cycle
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			compare_flag_q <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else begin
			compare_flag_q <= cf_set | (compare_flag_q & ~cf_clr);
			overflow_flag_q <= of_set | (overflow_flag_q & ~of_clr);
		end
	end

	// clk/2 divider and pin synchroniser
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 1'b0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
			pin_s1_q <= timer_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// counter state and pin drive
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= `TMR_RST_CNT;
			cap_q <= `TMR_RST_CNT;
			loaded_q <= 1'b0;
			pend_q <= 1'b0;
			seen_q <= 1'b0;
			stop_q <= 1'b0;
			timer_pin_out <= 1'b0;
			timer_pin_oe <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			cap_q <= cap_d;
			loaded_q <= loaded_d;
			pend_q <= pend_d;
			seen_q <= seen_d;
			stop_q <= stop_d;
			timer_pin_out <= pin_d;
			// pin is driven only in the two output modes while enabled
			timer_pin_oe <= wr_csr ? (csr_w[`TMR_B_TE] & out_mode_w) : (timer_enable_q & out_mode);
		end
	end

endmodule // tmr_channel

// >>> testbench/tmr_checker.sv
// tmr_checker.sv: port assertions for the timer channel
// assumes: bound to tmr_channel; csr fields are shadowed from landed bus writes
`timescale 1ns/10ps
`include "tmr_defs.vh"
module tmr_checker (
	input wire sys_clk,
	input wire nrst,
	input wire [`TMR_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire timer_pin_out,
	input wire timer_pin_oe,
	input wire compare_irq_ack,
	input wire compare_irq,
	input wire overflow_irq_ack,
	input wire overflow_irq
);
	reg [15:0] csr_q;
	wire wr_csr = avs_write && !avs_waitrequest && avs_address == `TMR_OFS_CSR;
	// shadow of the low csr bytes; flags are left to the bench
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			csr_q <= 16'h0000;
		else if (wr_csr) begin
			if (avs_byteenable[0])
				csr_q[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				csr_q[15:8] <= avs_writedata[15:8];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_rd_wait; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read not answered after one wait");
	property p_wr_wait; avs_write && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wr_wait: assert property (p_wr_wait) else $error("write not answered after one wait");
	property p_cnt_hi; avs_read && !avs_waitrequest && avs_address == `TMR_OFS_COUNT |-> avs_readdata[31:24] == 8'h00;
	endproperty
	a_cnt_hi: assert property (p_cnt_hi) else $error("count upper bits not zero");
	property p_cirq; compare_irq |-> csr_q[2]; endproperty
	a_cirq: assert property (p_cirq) else $error("compare irq while disabled");
	property p_oirq; overflow_irq |-> csr_q[1]; endproperty
	a_oirq: assert property (p_oirq) else $error("overflow irq while disabled");
	property p_cack; compare_irq_ack |=> !compare_irq; endproperty
	a_cack: assert property (p_cack) else $error("compare irq kept after ack");
	property p_oack; overflow_irq_ack |=> !overflow_irq; endproperty
	a_oack: assert property (p_oack) else $error("overflow irq kept after ack");
	property p_enpin;
		$rose(csr_q[0]) && (csr_q[7:4] == `TMR_M_PULSE || csr_q[7:4] == `TMR_M_TOGGLE)
			|-> timer_pin_out == csr_q[8] && timer_pin_oe;
	endproperty
	a_enpin: assert property (p_enpin) else $error("pin not set to polarity on enable");
	property p_pulse;
		csr_q[0] && csr_q[7:4] == `TMR_M_PULSE && !csr_q[15] && $changed(timer_pin_out) && timer_pin_out != csr_q[8]
			|=> timer_pin_out != csr_q[8] ##1 timer_pin_out == csr_q[8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse not one timer clock long");
	property p_idle; csr_q[7:4] == `TMR_M_TIMER && $past(csr_q[7:4]) == `TMR_M_TIMER |-> !timer_pin_oe; endproperty
	a_idle: assert property (p_idle) else $error("pin driven in plain timer mode");
endmodule // tmr_checker

// >>> testbench/tmr_pin_src.sv
// tmr_pin_src.sv: outside signal source feeding the timer pin
// assumes: half period above two cycles so the edge rate stays below clk/2
`timescale 1ns/10ps
module tmr_pin_src (
	input wire sys_clk,
	input wire run,
	input wire [7:0] half_per,
	output logic pin
);
	logic [7:0] cnt_q;
	initial pin = 1'b0;
	initial cnt_q = 8'h00;
	// toggles only while run is high, holds its level otherwise
	always @(posedge sys_clk) begin
		if (!run)
			cnt_q <= 8'h00;
		else if (cnt_q + 8'h01 >= half_per) begin
			cnt_q <= 8'h00;
			pin <= ~pin;
		end else
			cnt_q <= cnt_q + 8'h01;
	end
endmodule // tmr_pin_src

// >>> testbench/tb_top.sv
// tb_top.sv: self-checking bench for the timer channel
// assumes: design, checker and pin source compiled first
`timescale 1ns/10ps
`include "tmr_defs.vh"
module tb_top;
	logic sys_clk, nrst, avs_read, avs_write, prescaled_tick, src_run, src_pin, p, prev;
	logic compare_irq_ack, overflow_irq_ack, timer_pin_out, timer_pin_oe, compare_irq, overflow_irq;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q, c1;
	logic [1:0] ps_cnt;
	logic [7:0] hp;
	wire avs_waitrequest;
	wire timer_pin_in = timer_pin_oe ? timer_pin_out : src_pin;
	int n_fail, num_checks, n, k, m;
	tmr_channel tmr_channel_inst (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.prescaled_tick(prescaled_tick), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
		.timer_pin_oe(timer_pin_oe), .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
		.compare_irq(compare_irq), .overflow_irq(overflow_irq));
	tmr_pin_src tmr_pin_src_inst (.sys_clk(sys_clk), .run(src_run), .half_per(hp), .pin(src_pin));
	// 125 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// outside prescaler: one tick every four cycles
	always @(posedge sys_clk) begin
		ps_cnt <= ps_cnt + 2'h1;
		prescaled_tick <= (ps_cnt == 2'h3);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one bus cycle; waitrequest and read data are taken at the rising edge where waitrequest is low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && w < 50) begin
			w++;
			@(posedge sys_clk);
		end
		q = avs_readdata;
		if (w == 50)
			n_fail++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// cuts a hang short; the whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		complete_run;
	end
	// main sequence
	initial begin
		{nrst, avs_read, avs_write, src_run, compare_irq_ack, overflow_irq_ack, prescaled_tick} = 7'h00;
		avs_address = 4'h0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0;
		ps_cnt = 2'h0;
		hp = 8'h03;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(1'b0, `TMR_OFS_CSR, 32'h0);
		chk(q, `TMR_RST_WORD);
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		$display("reset and unmapped test done");
		bus(1'b1, `TMR_OFS_LOAD, 32'h5);
		bus(1'b1, `TMR_OFS_CMP, 32'h8);
		bus(1'b1, `TMR_OFS_CSR, 32'h205);
		for (n = 0; n < 60 && compare_irq !== 1'b1; n++) @(negedge sys_clk);
		chk({31'h0, compare_irq}, 32'h1);
		for (k = 0; k < 6; k++) begin
			bus(1'b0, `TMR_OFS_COUNT, 32'h0);
			chk({31'h0, q >= 32'h5 && q <= 32'h8}, 32'h1);
		end
		bus(1'b1, `TMR_OFS_CSR, 32'h204);
		bus(1'b0, `TMR_OFS_CSR, 32'h0);
		chk({31'h0, q[21]}, 32'h1);
		bus(1'b1, `TMR_OFS_CSR, 32'h200204);
		bus(1'b0, `TMR_OFS_CSR, 32'h0);
		chk({30'h0, q[21], compare_irq}, 32'h0);
		$display("compare and reload test done");
		bus(1'b1, `TMR_OFS_LOAD, 32'hFFFFFC);
		bus(1'b1, `TMR_OFS_CSR, 32'h3);
		for (n = 0; n < 40 && overflow_irq !== 1'b1; n++) @(negedge sys_clk);
		chk({31'h0, overflow_irq}, 32'h1);
		bus(1'b0, `TMR_OFS_COUNT, 32'h0);
		chk({31'h0, q < 32'h8}, 32'h1);
		bus(1'b1, `TMR_OFS_CSR, 32'h2);
		overflow_irq_ack <= 1'b1;
		@(posedge sys_clk);
		overflow_irq_ack <= 1'b0;
		bus(1'b0, `TMR_OFS_CSR, 32'h0);
		chk({30'h0, q[20], overflow_irq}, 32'h0);
		$display("overflow test done");
		bus(1'b1, `TMR_OFS_LOAD, 32'h0);
		bus(1'b1, `TMR_OFS_CMP, 32'h3);
		for (m = 1; m < 3; m++) for (k = 0; k < 2; k++) begin
			p = k[0];
			bus(1'b1, `TMR_OFS_CSR, 32'((m << 4) | (k << 8) | 32'h201));
			@(negedge sys_clk);
			chk({30'h0, timer_pin_out, timer_pin_oe}, {30'h0, p, 1'b1});
			for (n = 0; n < 40 && timer_pin_out === p; n++) @(negedge sys_clk);
			if (m == 1) begin
				for (n = 0; n < 9 && timer_pin_out !== p; n++) @(negedge sys_clk);
				chk(32'(n), 32'h2);
			end else begin
				chk({31'h0, timer_pin_out}, {31'h0, !p});
				for (n = 0; n < 20 && timer_pin_out !== p; n++) @(negedge sys_clk);
				chk({31'h0, timer_pin_out}, {31'h0, p});
			end
			bus(1'b1, `TMR_OFS_CSR, 32'h0);
		end
		$display("pin output test done");
		bus(1'b1, `TMR_OFS_CMP, 32'hFFFFFF);
		for (m = 0; m < 2; m++) begin
			p = m[0];
			bus(1'b1, `TMR_OFS_CSR, 32'((m << 8) | 32'h31));
			k = 0;
			prev = src_pin;
			src_run <= 1'b1;
			for (n = 0; n < 70; n++) begin
				@(negedge sys_clk);
				if (n == 60)
					src_run <= 1'b0;
				if (src_pin !== prev && src_pin !== p)
					k++;
				prev = src_pin;
			end
			bus(1'b0, `TMR_OFS_COUNT, 32'h0);
			chk(q, 32'(k - 1));
			bus(1'b1, `TMR_OFS_CSR, 32'h0);
		end
		$display("event count test done");
		p = src_pin;
		bus(1'b1, `TMR_OFS_CSR, 32'h208061 | {23'h0, p, 8'h00});
		repeat (40) @(negedge sys_clk);
		src_run <= 1'b1;
		for (n = 0; n < 10 && src_pin === p; n++) @(negedge sys_clk);
		src_run <= 1'b0;
		repeat (6) @(negedge sys_clk);
		bus(1'b0, `TMR_OFS_CSR, 32'h0);
		chk({31'h0, q[21]}, 32'h1);
		bus(1'b0, `TMR_OFS_COUNT, 32'h0);
		c1 = q;
		chk({31'h0, c1 >= 32'h8 && c1 <= 32'h10}, 32'h1);
		bus(1'b1, `TMR_OFS_CSR, 32'h208061 | {23'h0, p, 8'h00});
		src_run <= 1'b1;
		repeat (30) @(negedge sys_clk);
		src_run <= 1'b0;
		repeat (8) @(negedge sys_clk);
		bus(1'b0, `TMR_OFS_CSR, 32'h0);
		chk({31'h0, q[21]}, 32'h0);
		bus(1'b0, `TMR_OFS_COUNT, 32'h0);
		chk(q, c1);
		bus(1'b1, `TMR_OFS_CSR, 32'h0);
		$display("capture test done");
		// width and period with reload: 16-cycle levels give 8 or 16 timer clocks, first one loads
		hp <= 8'h10;
		for (m = 4; m < 6; m++) begin
			bus(1'b1, `TMR_OFS_CSR, 32'((m << 4) | 32'h300201));
			src_run <= 1'b1;
			repeat (120) @(negedge sys_clk);
			bus(1'b0, `TMR_OFS_CSR, 32'h0);
			chk({31'h0, q[21]}, 32'h1);
			bus(1'b0, `TMR_OFS_COUNT, 32'h0);
			k = (m == 4) ? 6 : 14;
			chk({31'h0, q >= k && q <= k + 2}, 32'h1);
			src_run <= 1'b0;
			bus(1'b1, `TMR_OFS_CSR, 32'h0);
		end
		$display("measurement test done");
		complete_run;
	end
endmodule // tb_top
bind tmr_channel tmr_checker tmr_checker_inst (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_pin_out(timer_pin_out),
	.timer_pin_oe(timer_pin_oe), .compare_irq_ack(compare_irq_ack), .compare_irq(compare_irq),
	.overflow_irq_ack(overflow_irq_ack), .overflow_irq(overflow_irq));
